// ==== rtl/dlp_pkg.sv ====
`default_nettype none
package dlp_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] DLP_IDX_RESET  = 8'h1a;
    localparam logic [7:0] DLP_IDX_GEN_W  = 8'h1b;
    localparam logic [7:0] DLP_IDX_RXC_W  = 8'h1c;
    localparam logic [7:0] DLP_IDX_RXM_W  = 8'h1d;
    localparam logic [7:0] DLP_IDX_OFS_W  = 8'h1f;
    localparam logic [7:0] DLP_IDX_M0_W   = 8'h2a;
    localparam logic [7:0] DLP_IDX_M1_W   = 8'h2b;
    localparam logic [7:0] DLP_IDX_M2_W   = 8'h2c;
    localparam logic [7:0] DLP_IDX_R0_W   = 8'h2d;
    localparam logic [7:0] DLP_IDX_R1_W   = 8'h2e;
    localparam logic [7:0] DLP_IDX_VCO_W  = 8'h2f;
    localparam logic [7:0] DLP_IDX_GEN_R  = 8'heb;
    localparam logic [7:0] DLP_IDX_RXC_R  = 8'hec;
    localparam logic [7:0] DLP_IDX_RXM_R  = 8'hed;
    localparam logic [7:0] DLP_IDX_OFS_R  = 8'hef;
    localparam logic [7:0] DLP_IDX_M0_R   = 8'hda;
    localparam logic [7:0] DLP_IDX_M1_R   = 8'hdb;
    localparam logic [7:0] DLP_IDX_M2_R   = 8'hdc;
    localparam logic [7:0] DLP_IDX_R0_R   = 8'hdd;
    localparam logic [7:0] DLP_IDX_R1_R   = 8'hde;
    localparam logic [7:0] DLP_IDX_VCO_R  = 8'hdf;
    localparam logic [7:0] DLP_REG_RST    = 8'h00;
    // general control fields
    localparam int DLP_GEN_DIV2   = 7;
    localparam int DLP_GEN_AMP    = 5;
    localparam int DLP_GEN_BIAS   = 4;
    localparam int DLP_GEN_VCO    = 3;
    localparam int DLP_GEN_SYNTH  = 2;
    localparam int DLP_GEN_DEMOD  = 1;
    // receiver control / mode fields
    localparam int DLP_RXC_DRIVE  = 7;
    localparam int DLP_RXC_COR    = 6;
    localparam int DLP_RXM_NOI    = 7;
    localparam int DLP_RXM_NOQ    = 6;
    localparam int DLP_RXM_INVI   = 5;
    localparam int DLP_RXM_INVQ   = 4;
    // top divider byte: enable, charge-pump float, lock on read
    localparam int DLP_M2_EN      = 7;
    localparam int DLP_M2_HIZ     = 6;
    localparam int DLP_M2_LOCK    = 6;
    // offset register: per channel polarity bit above three source bits
    localparam int DLP_OFS_IPOL   = 3;
    localparam int DLP_OFS_QPOL   = 7;
    // lock detection timing
    localparam int DLP_CLK_MHZ      = 125;
    localparam int DLP_LOCK_WIN_NS  = 40;
    localparam logic [7:0] DLP_LOCK_WIN_CYC =
        8'(DLP_LOCK_WIN_NS * DLP_CLK_MHZ / 1000);
    localparam logic [4:0] DLP_LOCK_COUNT = 5'h10;
endpackage
`default_nettype wire

// ==== rtl/dlp_ctrl.sv ====
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module dlp_ctrl #(
    parameter logic [4:0] LOCK_COUNT = dlp_pkg::DLP_LOCK_COUNT
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    input  wire logic        CE,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [9:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        SYNTH_REFERENCE_IN,
    input  wire logic        EXTERNAL_LO_PIN,
    input  wire logic        VCO_OSC_IN,
    output logic             CP_UP,
    output logic             CP_DN,
    output logic             CP_OE,
    output logic             SYNTH_ACTIVE,
    output logic             SYNTH_LOCKED,
    output logic             VCO_POWER_ON,
    output logic             SYNTH_POWER_ON,
    output logic             DEMOD_POWER_ON,
    output logic             EXT_LO_PATH_ON,
    output logic             ILLEGAL_LO_MODE,
    output logic             LO_DIVIDE_SELECT,
    output logic             BIAS_ON,
    output logic             AMP1_ON,
    output logic             AMP2_ON,
    output logic             I_CH_ON,
    output logic             Q_CH_ON,
    output logic             IQ_CORRECTION_ON,
    output logic             HIGH_OUTPUT_DRIVE,
    output logic      [2:0]  IF_GAIN_STEP,
    output logic      [1:0]  BB_GAIN_STEP,
    output logic      [3:0]  LO_AMPLITUDE_CODE,
    output logic      [2:0]  OFFSET_SOURCE_POS_I,
    output logic      [2:0]  OFFSET_SOURCE_NEG_I,
    output logic      [2:0]  OFFSET_SOURCE_POS_Q,
    output logic      [2:0]  OFFSET_SOURCE_NEG_Q,
    output logic      [1:0]  NEGATIVE_RESISTANCE_LEVEL,
    output logic      [1:0]  INTERMOD_TUNING
);
    import dlp_pkg::*;

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdat;
        logic [7:0]  gen;
        logic [7:0]  rxc;
        logic [7:0]  rxm;
        logic [7:0]  ofs;
        logic [7:0]  m0;
        logic [7:0]  m1;
        logic [7:0]  m2;
        logic [7:0]  r0;
        logic [7:0]  r1;
        logic [7:0]  vco;
        logic        ref1;
        logic        ref2;
        logic        ref3;
        logic        ext1;
        logic        ext2;
        logic        ext3;
        logic        osc1;
        logic        osc2;
        logic        osc3;
        logic [15:0] rcnt;
        logic [21:0] mcnt;
        logic        up;
        logic        dn;
        logic [7:0]  pw;
        logic [4:0]  lkc;
        logic        locked;
    } dlp_state_t;

    dlp_state_t q;
    dlp_state_t d;

    logic [7:0]  idx;
    logic        mode_vco;
    logic        mode_synth;
    logic        mode_demod;
    logic        mode_ext;
    logic        mode_bad;
    logic        synth_act;
    logic [15:0] r_lim;
    logic [21:0] m_lim;
    logic [15:0] r_val;
    logic [21:0] m_val;
    logic        ref_edge;
    logic        fb_edge;
    logic        ref_p;
    logic        fb_p;
    logic        nup;
    logic        ndn;
    logic        difamp;

    assign idx = ADR_I[9:2];

    // lo routing decode; illegal codes switch everything off as a safe state
    always_comb begin
        mode_vco   = 1'b0;
        mode_synth = 1'b0;
        mode_demod = 1'b0;
        mode_ext   = 1'b0;
        mode_bad   = 1'b0;
        unique case (q.gen[DLP_GEN_VCO:DLP_GEN_DEMOD])
            3'h0: begin
            end
            3'h1: begin
                mode_demod = 1'b1;
                mode_ext   = 1'b1;
            end
            3'h3: begin
                mode_demod = 1'b1;
                mode_synth = 1'b1;
                mode_ext   = 1'b1;
            end
            3'h7: begin
                mode_demod = 1'b1;
                mode_synth = 1'b1;
                mode_vco   = 1'b1;
            end
            default: begin
                mode_bad = 1'b1;
            end
        endcase
    end

    // the synthesiser needs both enables
    assign synth_act = mode_synth & q.m2[DLP_M2_EN];

    // divide values; zero is treated as one so the counters never stall
    assign r_val = {q.r1, q.r0};
    assign m_val = {q.m2[5:0], q.m1, q.m0};
    assign r_lim = (r_val == 16'h0000) ? 16'h0000 : r_val - 16'h0001;
    assign m_lim = (m_val == 22'h000000) ? 22'h000000 : m_val - 22'h000001;

    // edges from the second and third stages; first stages feed nothing else
    assign ref_edge = q.ref2 & ~q.ref3;
    assign fb_edge  = mode_vco ? (q.osc2 & ~q.osc3) : (q.ext2 & ~q.ext3);

    // next-state logic for the whole block
    always_comb begin
        d     = q;
        ref_p = 1'b0;
        fb_p  = 1'b0;
        nup   = 1'b0;
        ndn   = 1'b0;

        // three-stage synchronisers for the pin clocks
        d.ref1 = SYNTH_REFERENCE_IN;
        d.ref2 = q.ref1;
        d.ref3 = q.ref2;
        d.ext1 = EXTERNAL_LO_PIN;
        d.ext2 = q.ext1;
        d.ext3 = q.ext2;
        d.osc1 = VCO_OSC_IN;
        d.osc2 = q.osc1;
        d.osc3 = q.osc2;

        // classic wishbone: answer one cycle after the strobe, then drop
        d.ack = 1'b0;
        if (CYC_I && STB_I && !q.ack) begin
            d.ack  = 1'b1;
            d.rdat = 8'h00;
            if (WE_I) begin
                if (SEL_I[0]) begin
                    case (idx)
                        DLP_IDX_RESET: begin
                            d.gen = DLP_REG_RST;
                            d.rxc = DLP_REG_RST;
                            d.rxm = DLP_REG_RST;
                            d.ofs = DLP_REG_RST;
                            d.m0  = DLP_REG_RST;
                            d.m1  = DLP_REG_RST;
                            d.m2  = DLP_REG_RST;
                            d.r0  = DLP_REG_RST;
                            d.r1  = DLP_REG_RST;
                            d.vco = DLP_REG_RST;
                        end
                        DLP_IDX_GEN_W: d.gen = DAT_I[7:0];
                        DLP_IDX_RXC_W: d.rxc = DAT_I[7:0];
                        DLP_IDX_RXM_W: d.rxm = DAT_I[7:0];
                        DLP_IDX_OFS_W: d.ofs = DAT_I[7:0];
                        DLP_IDX_M0_W:  d.m0  = DAT_I[7:0];
                        DLP_IDX_M1_W:  d.m1  = DAT_I[7:0];
                        DLP_IDX_M2_W:  d.m2  = DAT_I[7:0];
                        DLP_IDX_R0_W:  d.r0  = DAT_I[7:0];
                        DLP_IDX_R1_W:  d.r1  = DAT_I[7:0];
                        DLP_IDX_VCO_W: d.vco = DAT_I[7:0];
                        default: begin
                        end
                    endcase
                end
            end else begin
                // read-only mirrors; unmapped indices read zero
                case (idx)
                    DLP_IDX_GEN_R: d.rdat = q.gen;
                    DLP_IDX_RXC_R: d.rdat = q.rxc;
                    DLP_IDX_RXM_R: d.rdat = q.rxm;
                    DLP_IDX_OFS_R: d.rdat = q.ofs;
                    DLP_IDX_M0_R:  d.rdat = q.m0;
                    DLP_IDX_M1_R:  d.rdat = q.m1;
                    DLP_IDX_M2_R: begin
                        d.rdat = q.m2;
                        d.rdat[DLP_M2_LOCK] = q.locked;
                    end
                    DLP_IDX_R0_R:  d.rdat = q.r0;
                    DLP_IDX_R1_R:  d.rdat = q.r1;
                    DLP_IDX_VCO_R: d.rdat = q.vco;
                    default:       d.rdat = 8'h00;
                endcase
            end
        end

        // dividers and phase detector run only while the loop is active
        if (!synth_act) begin
            d.rcnt   = 16'h0000;
            d.mcnt   = 22'h000000;
            d.up     = 1'b0;
            d.dn     = 1'b0;
            d.pw     = 8'h00;
            d.lkc    = 5'h00;
            d.locked = 1'b0;
        end else begin
            // reference divider sets the comparison rate
            if (ref_edge) begin
                if (q.rcnt >= r_lim) begin
                    d.rcnt = 16'h0000;
                    ref_p  = 1'b1;
                end else begin
                    d.rcnt = q.rcnt + 16'h0001;
                end
            end
            // feedback divider on the selected lo source
            if (fb_edge) begin
                if (q.mcnt >= m_lim) begin
                    d.mcnt = 22'h000000;
                    fb_p   = 1'b1;
                end else begin
                    d.mcnt = q.mcnt + 22'h000001;
                end
            end
            // reference first means vco slow: pump up raises tuning voltage
            nup = q.up | ref_p;
            ndn = q.dn | fb_p;
            if (nup && ndn) begin
                d.up = 1'b0;
                d.dn = 1'b0;
                d.pw = 8'h00;
                // a short error pulse counts toward lock, a long one breaks it
                if (q.pw <= DLP_LOCK_WIN_CYC) begin
                    if (q.lkc != LOCK_COUNT) begin
                        d.lkc = q.lkc + 5'h01;
                    end
                end else begin
                    d.lkc = 5'h00;
                end
            end else begin
                d.up = nup;
                d.dn = ndn;
                if ((nup || ndn) && q.pw != 8'hff) begin
                    d.pw = q.pw + 8'h01;
                end
                // a pulse that outgrows the window drops lock at once
                if (q.pw > DLP_LOCK_WIN_CYC) begin
                    d.lkc = 5'h00;
                end
            end
            d.locked = (d.lkc == LOCK_COUNT);
        end
    end

    // single state register; reset clears it even with clock enable low, which otherwise freezes everything
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            q <= '0;
        end else if (CE) begin
            q <= d;
        end
    end

    // bus outputs
    assign DAT_O = {24'h000000, q.rdat};
    assign ACK_O = q.ack;

    // charge pump floats when forced or when the loop is off
    assign CP_OE = synth_act & ~q.m2[DLP_M2_HIZ];
    assign CP_UP = q.up & CP_OE;
    assign CP_DN = q.dn & CP_OE;

    assign SYNTH_ACTIVE    = synth_act;
    assign SYNTH_LOCKED    = q.locked;
    assign VCO_POWER_ON    = mode_vco;
    assign SYNTH_POWER_ON  = mode_synth;
    assign DEMOD_POWER_ON  = mode_demod;
    assign EXT_LO_PATH_ON  = mode_ext;
    assign ILLEGAL_LO_MODE = mode_bad;

    // lo divide: set gives divide by two
    assign LO_DIVIDE_SELECT = q.gen[DLP_GEN_DIV2];
    assign BIAS_ON          = q.gen[DLP_GEN_BIAS];

    // amplifier enables, each optionally inverted to follow i or q
    assign difamp  = q.gen[DLP_GEN_AMP];
    assign AMP1_ON = difamp ^ q.rxm[DLP_RXM_INVI];
    assign AMP2_ON = difamp ^ q.rxm[DLP_RXM_INVQ];

    // channel select; the reserved code leaves both channels off
    assign I_CH_ON = mode_demod & ~q.rxm[DLP_RXM_NOI];
    assign Q_CH_ON = mode_demod & ~q.rxm[DLP_RXM_NOQ];

    // receiver options straight from their register bits
    assign IQ_CORRECTION_ON  = q.rxc[DLP_RXC_COR];
    assign HIGH_OUTPUT_DRIVE = q.rxc[DLP_RXC_DRIVE];
    assign IF_GAIN_STEP      = q.rxc[4:2];
    assign BB_GAIN_STEP      = q.rxc[1:0];
    assign LO_AMPLITUDE_CODE = q.rxm[3:0];

    // offset sources: one polarity at a time so they never fight
    assign OFFSET_SOURCE_POS_I = q.ofs[DLP_OFS_IPOL] ? 3'h0 : q.ofs[2:0];
    assign OFFSET_SOURCE_NEG_I = q.ofs[DLP_OFS_IPOL] ? q.ofs[2:0] : 3'h0;
    assign OFFSET_SOURCE_POS_Q = q.ofs[DLP_OFS_QPOL] ? 3'h0 : q.ofs[6:4];
    assign OFFSET_SOURCE_NEG_Q = q.ofs[DLP_OFS_QPOL] ? q.ofs[6:4] : 3'h0;

    // oscillator settings
    assign NEGATIVE_RESISTANCE_LEVEL = q.vco[1:0];
    assign INTERMOD_TUNING           = q.vco[3:2];

endmodule
`default_nettype wire

// ==== tb/dlp_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlp_ctrl_checker #(
    parameter logic [4:0] LOCK_COUNT = dlp_pkg::DLP_LOCK_COUNT
) (
    input wire logic       CLK_SYS,
    input wire logic       SRST,
    input wire logic       CE,
    input wire logic       CYC_I,
    input wire logic       STB_I,
    input wire logic       ACK_O,
    input wire logic       CP_UP,
    input wire logic       CP_DN,
    input wire logic       CP_OE,
    input wire logic       SYNTH_ACTIVE,
    input wire logic       SYNTH_LOCKED,
    input wire logic       VCO_POWER_ON,
    input wire logic       SYNTH_POWER_ON,
    input wire logic       DEMOD_POWER_ON,
    input wire logic       EXT_LO_PATH_ON,
    input wire logic       ILLEGAL_LO_MODE,
    input wire logic [3:0] LO_AMPLITUDE_CODE
);
    // cycles of continuous loop activity; lock cannot come sooner than the count
    logic [7:0] act_q;
    always_ff @(posedge CLK_SYS) begin
        if (SRST || !SYNTH_ACTIVE) begin
            act_q <= 8'h00;
        end else if (act_q != 8'hff) begin
            act_q <= act_q + 8'h01;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // bus answer is a single pulse one cycle after the taken request
    ack_one_cycle_a: assert property (ACK_O && CE |=> !ACK_O)
        else $error("ack held beyond one cycle");
    ack_follows_req_a: assert property (CYC_I && STB_I && !ACK_O && CE |=> ACK_O)
        else $error("request not answered in the next cycle");
    reset_clears_a: assert property (disable iff (1'b0) SRST && CE |=>
        !ACK_O && !SYNTH_LOCKED && LO_AMPLITUDE_CODE == 4'h0)
        else $error("state not cleared by reset");
    lo_mode_legal_a: assert property (!ILLEGAL_LO_MODE |->
        {VCO_POWER_ON, SYNTH_POWER_ON, DEMOD_POWER_ON} inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("undecoded lo mode");
    ext_lo_gate_a: assert property (VCO_POWER_ON |-> !EXT_LO_PATH_ON)
        else $error("external lo path on with vco");
    synth_gate_a: assert property (SYNTH_ACTIVE |-> SYNTH_POWER_ON && !ILLEGAL_LO_MODE)
        else $error("synthesiser active without enable");
    cp_quiet_a: assert property (!SYNTH_ACTIVE [*2] |-> !CP_UP && !CP_DN && !SYNTH_LOCKED)
        else $error("loop busy while inactive");
    cp_float_a: assert property (!CP_OE |-> !CP_UP && !CP_DN)
        else $error("charge pump pulses while floating");
    lock_after_count_a: assert property ($rose(SYNTH_LOCKED) |-> act_q > {3'h0, LOCK_COUNT})
        else $error("lock flagged too early");
    cover property ($rose(SYNTH_LOCKED));
    cover property (ILLEGAL_LO_MODE);
    cover property (CP_UP && CP_OE);
endmodule
bind dlp_ctrl dlp_ctrl_checker #(.LOCK_COUNT(LOCK_COUNT)) u_chk (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .CP_UP(CP_UP), .CP_DN(CP_DN), .CP_OE(CP_OE), .SYNTH_ACTIVE(SYNTH_ACTIVE),
    .SYNTH_LOCKED(SYNTH_LOCKED), .VCO_POWER_ON(VCO_POWER_ON), .SYNTH_POWER_ON(SYNTH_POWER_ON),
    .DEMOD_POWER_ON(DEMOD_POWER_ON), .EXT_LO_PATH_ON(EXT_LO_PATH_ON),
    .ILLEGAL_LO_MODE(ILLEGAL_LO_MODE), .LO_AMPLITUDE_CODE(LO_AMPLITUDE_CODE));
`default_nettype wire

// ==== tb/dlp_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlp_osc_model (
    input  wire logic       vco_on,
    input  wire logic       ext_on,
    input  wire logic       cp_up,
    input  wire logic       cp_dn,
    input  wire logic [7:0] fb_half_ns,
    output logic            ref_clk,
    output logic            vco_clk,
    output logic            ext_clk
);
    // positive tuning slope: pumping up shortens the period
    function automatic int half_ns();
        return int'(fb_half_ns) - (cp_up ? 2 : 0) + (cp_dn ? 2 : 0);
    endfunction
    // reference oscillator runs free at the 80 ns rate
    initial ref_clk = 1'b0;
    always #40 ref_clk = ~ref_clk;
    // on-chip vco follows its power enable and rests low when off
    always begin
        if (vco_on === 1'b1) begin
            #(half_ns()) vco_clk = ~vco_clk;
        end else begin
            vco_clk = 1'b0;
            #3;
        end
    end
    // external vco on the lo pin, steered by the same pump
    always begin
        if (ext_on === 1'b1) begin
            #(half_ns()) ext_clk = ~ext_clk;
        end else begin
            ext_clk = 1'b0;
            #3;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_demod_lo_pll_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_demod_lo_pll_control;
    import dlp_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        ext_on = 1'b0;
    logic        ce = 1'b1;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [7:0]  fbh = 8'h28;
    logic [31:0] d_o, rd;
    logic        ack, cpu, cpd, cpoe, sact, lck, pv, ps, pd, pe, ill, div, bias;
    logic        a1, a2, ich, qch, iq, hd, refc, vcoc, extc;
    logic [2:0]  ifg, opi, oni, opq, onq;
    logic [1:0]  bbg, nr, intermod_tuning;
    logic [3:0]  loa;
    logic [37:0] obs;
    logic [7:0]  val [9];
    int          fails = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          up_n, dn_n;
    // write indices and read mirrors in the same order
    logic [7:0] wi [9] = '{DLP_IDX_GEN_W, DLP_IDX_RXC_W, DLP_IDX_RXM_W, DLP_IDX_OFS_W,
        DLP_IDX_VCO_W, DLP_IDX_M0_W, DLP_IDX_M1_W, DLP_IDX_R0_W, DLP_IDX_R1_W};
    logic [7:0] ri [9] = '{DLP_IDX_GEN_R, DLP_IDX_RXC_R, DLP_IDX_RXM_R, DLP_IDX_OFS_R,
        DLP_IDX_VCO_R, DLP_IDX_M0_R, DLP_IDX_M1_R, DLP_IDX_R0_R, DLP_IDX_R1_R};
    logic [2:0] lm [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic [3:0] amp [7] = '{4'h4, 4'h8, 4'hc, 4'hd, 4'he, 4'hf, 4'h0};
    // loop cases: general control, m, r, feedback half period in ns
    // divide by two and even m keep the lo spur free; zero m is the corner case
    logic [31:0] pll [5] = '{32'h8e020114, 32'h8e040214, 32'h8e020228, 32'h8e000028,
        32'h86020114};
    always #4 clk_sys = ~clk_sys;
    dlp_ctrl #(.LOCK_COUNT(5'h04)) uut (
        .CLK_SYS(clk_sys), .SRST(srst), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(d_o), .ACK_O(ack),
        .SYNTH_REFERENCE_IN(refc), .EXTERNAL_LO_PIN(extc), .VCO_OSC_IN(vcoc),
        .CP_UP(cpu), .CP_DN(cpd), .CP_OE(cpoe), .SYNTH_ACTIVE(sact), .SYNTH_LOCKED(lck),
        .VCO_POWER_ON(pv), .SYNTH_POWER_ON(ps), .DEMOD_POWER_ON(pd), .EXT_LO_PATH_ON(pe),
        .ILLEGAL_LO_MODE(ill), .LO_DIVIDE_SELECT(div), .BIAS_ON(bias), .AMP1_ON(a1),
        .AMP2_ON(a2), .I_CH_ON(ich), .Q_CH_ON(qch), .IQ_CORRECTION_ON(iq),
        .HIGH_OUTPUT_DRIVE(hd), .IF_GAIN_STEP(ifg), .BB_GAIN_STEP(bbg),
        .LO_AMPLITUDE_CODE(loa), .OFFSET_SOURCE_POS_I(opi), .OFFSET_SOURCE_NEG_I(oni),
        .OFFSET_SOURCE_POS_Q(opq), .OFFSET_SOURCE_NEG_Q(onq),
        .NEGATIVE_RESISTANCE_LEVEL(nr), .INTERMOD_TUNING(intermod_tuning));
    dlp_osc_model osc (.vco_on(pv), .ext_on(ext_on), .cp_up(cpu), .cp_dn(cpd),
        .fb_half_ns(fbh), .ref_clk(refc), .vco_clk(vcoc), .ext_clk(extc));
    assign obs = {div, bias, pv, ps, pd, pe, ill, a1, a2, ich, qch, iq, hd, ifg, bbg, loa,
        opi, oni, opq, onq, nr, intermod_tuning};
    // expected static outputs from general, rx control, rx mode, offset and vco bytes
    function automatic logic [37:0] exp_out(input logic [7:0] g, c, m, o, v);
        logic       bad;
        logic [3:0] md;
        bad = !(g[3:1] inside {3'h0, 3'h1, 3'h3, 3'h7});
        md = bad ? 4'h0 : {g[3:1], g[1] & ~g[3]};
        return {g[7], g[4], md, bad, g[5] ^ m[5], g[5] ^ m[4], md[1] & ~m[7], md[1] & ~m[6],
            c[6], c[7], c[4:2], c[1:0], m[3:0], o[3] ? 3'h0 : o[2:0], o[3] ? o[2:0] : 3'h0,
            o[7] ? 3'h0 : o[6:4], o[7] ? o[6:4] : 3'h0, v[1:0], v[3:2]};
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; holds the request until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        sel <= s;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) fails++;
        rd = d_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_lock();
        int n;
        n = 0;
        while (lck !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard; the whole sequence needs well under this
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'he5b54dc4));
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            wb(1'b0, ri[k], 8'h00, 4'hf);
            chk({8'h0, rd}, 40'h0);
        end
        chk({2'h0, obs}, 40'h0);
        // random legal settings, every lo mode and seven amplitude codes
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 9; k++) val[k] = 8'($urandom);
            val[0][3:1] = lm[i % 4];
            val[0][6] = 1'b0;
            val[0][0] = 1'b0;
            val[1][5] = 1'b0;
            val[1][3] = val[1][3] & ~val[1][4]; // reserved gain steps 110, 111 avoided
            val[2][3:0] = amp[i % 7];
            val[2][7] = val[2][7] & ~val[2][6];
            val[4][7:4] = 4'h0;
            for (int k = 0; k < 9; k++) wb(1'b1, wi[k], val[k], 4'hf);
            for (int k = 0; k < 9; k++) begin
                wb(1'b0, ri[k], 8'h00, 4'hf);
                chk({8'h0, rd}, {32'h0, val[k]});
            end
            chk({2'h0, obs}, {2'h0, exp_out(val[0], val[1], val[2], val[3], val[4])});
        end
        // illegal mode is taken, then refused cases: no byte lane, unmapped and read-only places
        wb(1'b1, DLP_IDX_GEN_W, 8'h04, 4'hf);
        chk({2'h0, obs}, {2'h0, exp_out(8'h04, val[1], val[2], val[3], val[4])});
        wb(1'b1, DLP_IDX_GEN_W, 8'hff, 4'he);
        wb(1'b1, DLP_IDX_GEN_R, 8'hff, 4'hf);
        wb(1'b1, 8'h1e, 8'hff, 4'hf);
        wb(1'b0, 8'h1e, 8'h00, 4'hf);
        chk({8'h0, rd}, 40'h0);
        wb(1'b0, DLP_IDX_GEN_R, 8'h00, 4'hf);
        chk({8'h0, rd}, 40'h04);
        // reset in mid-run, then the general reset command
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        chk({2'h0, obs}, 40'h0);
        wb(1'b1, DLP_IDX_RXM_W, 8'h3f, 4'hf);
        wb(1'b1, DLP_IDX_RESET, 8'h00, 4'hf);
        chk({2'h0, obs}, 40'h0);
        // loop locks for each divide pair and lo source
        for (int j = 0; j < 5; j++) begin
            ext_on <= (pll[j][31:24] == 8'h86);
            fbh <= pll[j][7:0];
            wb(1'b1, DLP_IDX_GEN_W, pll[j][31:24], 4'hf);
            wb(1'b1, DLP_IDX_M0_W, pll[j][23:16], 4'hf);
            wb(1'b1, DLP_IDX_R0_W, pll[j][15:8], 4'hf);
            wb(1'b1, DLP_IDX_M2_W, 8'h80, 4'hf);
            chk({39'h0, sact}, 40'h1);
            wait_lock();
            chk({39'h0, lck}, 40'h1);
            wb(1'b0, DLP_IDX_M2_R, 8'h00, 4'hf);
            chk({8'h0, rd}, 40'hc0);
            // a low clock enable must freeze the lock flag with the rest
            ce <= 1'b0;
            repeat (20) @(posedge clk_sys);
            chk({39'h0, lck}, 40'h1);
            ce <= 1'b1;
            wb(1'b1, DLP_IDX_M2_W, 8'hc0, 4'hf);
            chk({39'h0, cpoe}, 40'h0);
            wb(1'b1, DLP_IDX_M2_W, 8'h00, 4'hf);
            repeat (3) @(posedge clk_sys);
            chk({38'h0, sact, lck}, 40'h0);
        end
        // vco far too slow: pump must mostly push upward
        ext_on <= 1'b0;
        fbh <= 8'h50;
        wb(1'b1, DLP_IDX_GEN_W, 8'h8e, 4'hf);
        wb(1'b1, DLP_IDX_M0_W, 8'h01, 4'hf);
        wb(1'b1, DLP_IDX_R0_W, 8'h01, 4'hf);
        wb(1'b1, DLP_IDX_M2_W, 8'h80, 4'hf);
        chk({39'h0, cpoe}, 40'h1);
        up_n = 0;
        dn_n = 0;
        repeat (400) begin
            @(posedge clk_sys);
            up_n += int'(cpu === 1'b1);
            dn_n += int'(cpd === 1'b1);
        end
        chk({39'h0, up_n > dn_n}, 40'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
